// [hbd_pkg.sv]
// Purpose: Shared constants and types for the HDLC buffer transfer block
// Assumes: APB register word per register, 8-bit message bytes
// Notes: Offsets are byte addresses on the APB port
`default_nettype none
package hbd_pkg;
  localparam logic [7:0] HBD_TX_CFG_OFS = 8'h00;
  localparam logic [7:0] HBD_RX_CFG_OFS = 8'h04;
  localparam logic [7:0] HBD_TX_LEN_OFS = 8'h08;
  localparam logic [7:0] HBD_STAT_OFS = 8'h0c;
  localparam int HBD_RST_BIT = 7;
  localparam int HBD_EN_BIT = 6;
  localparam int HBD_TYPE_BIT = 5;
  localparam logic [7:0] HBD_CFG_WMASK = 8'he7;
  localparam logic [7:0] HBD_CFG_RST_VAL = 8'h00;
  localparam logic [7:0] HBD_LEN_RST_VAL = 8'h10;
  localparam logic [2:0] HBD_SEL_CH0 = 3'h0;
  localparam logic [2:0] HBD_SEL_RX_RSVD = 3'h1;
  localparam logic [1:0] HBD_SEL_LOW_RSVD = 2'h3;
  localparam int HBD_FIFO_DEPTH = 8;
  localparam int HBD_BYTE_W = 8;
  localparam int HBD_PIN_W = 12;
  localparam logic [11:0] HBD_PIN_RST_VAL = 12'hfff;

  typedef enum logic [1:0] {
    HBD_IDLE = 2'b00,
    HBD_ACT = 2'b01,
    HBD_DONE = 2'b11
  } hbd_chan_st_t;

  // A line code is usable when it is not reserved and names this line
  function automatic logic hbd_sel_ok(input logic [2:0] sel, input logic is_rx, input logic [2:0] line);
    logic rsvd;
    rsvd = sel[2] | (sel[1:0] == HBD_SEL_LOW_RSVD) | (is_rx & (sel == HBD_SEL_RX_RSVD));
    return !rsvd && (sel == line);
  endfunction
endpackage
`default_nettype wire

// [hbd_strm_if.sv]
// Purpose: Valid/ready byte stream between internal modules
// Assumes: Transfer when valid and ready are high at a rising edge
// Notes: None
`default_nettype none
interface hbd_strm_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// [hbd_sync.sv]
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Each bit is a level that may change at any time
// Notes: The first stage feeds only the second
`default_nettype none
module hbd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule
`default_nettype wire

// [hbd_fifo.sv]
// Purpose: Byte FIFO between the memory strobe side and the message buffer
// Assumes: Synchronous clear drops all content
// Notes: Ready on the filling side is low while full
`default_nettype none
module hbd_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clr_i,
  hbd_strm_if.snk in_s,
  hbd_strm_if.src out_s,
  output logic [$clog2(D):0] level_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire logic push = in_s.valid & in_s.ready;
  wire logic pop = out_s.valid & out_s.ready;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_s.ready = (cnt_r != (AW+1)'(D));
  assign out_s.valid = (cnt_r != '0);
  assign out_s.data = mem[rp_r];
  assign level_o = cnt_r;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= in_s.data;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (clr_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= ptr_inc(wp_r);
      if (pop) rp_r <= ptr_inc(rp_r);
      if (push & ~pop) cnt_r <= (AW+1)'(cnt_r + 1'b1);
      else if (pop & ~push) cnt_r <= (AW+1)'(cnt_r - 1'b1);
    end
  end
endmodule
`default_nettype wire

// [hbd_xfer_top.sv]
// Purpose: Two request/grant byte channels between external memory and HDLC buffers
// Assumes: Store/fetch strobes, grants and data bus arrive asynchronously
// Notes: Registers over APB; pins pass two flip-flops first
// How it works
// - Writing bit 7 of the tx config from 0 to 1 resets the memory-to-buffer channel.
// - Writing bit 7 of the rx config from 0 to 1 resets the buffer-to-memory channel.
// - Bit 6 of the tx config enables the memory-to-buffer channel.
// - The tx channel starts requesting only when the buffer reports room for a whole message.
// - A tx cycle starts with the request low; bytes are taken only with the grant low.
// - Tx config bit 5 picks the store line (1) or the fetch line (0) as data strobe.
// - Tx config bits 2:0 pick the line channel; reserved codes keep the channel idle.
// - Rx config bit 6 enables the rx channel, which requests only for a complete message.
// - An rx cycle starts with the request low; bytes are given only with the grant low.
// - The device drives a new byte onto the bus at each low strobe of the chosen line.
// - Rx config bit 5 picks the fetch line (0) or the store line (1) as data strobe.
// - Rx config bits 2:0 pick the line channel; reserved codes keep the channel idle.
`default_nettype none
module hbd_xfer_top
  import hbd_pkg::*;
#(
  parameter int FIFO_DEPTH = HBD_FIFO_DEPTH,
  parameter logic [2:0] LINE_ID = HBD_SEL_CH0
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic store_n_i,
  input wire logic fetch_n_i,
  input wire logic tx_xfer_grant_n_i,
  input wire logic rx_xfer_grant_n_i,
  output logic tx_xfer_request_n_o,
  output logic rx_xfer_request_n_o,
  input wire logic [7:0] bus_data_i,
  output logic [7:0] bus_data_o,
  output logic bus_data_oe_o,
  input wire logic tx_buf_room_i,
  output logic [7:0] tx_buf_data_o,
  output logic tx_buf_valid_o,
  input wire logic tx_buf_ready_i,
  input wire logic rx_buf_msg_i,
  input wire logic [7:0] rx_buf_len_i,
  input wire logic [7:0] rx_buf_data_i,
  input wire logic rx_buf_valid_i,
  output logic rx_buf_ready_o
);
  logic [7:0] tx_cfg_r, rx_cfg_r, tx_len_r, rx_len_r;
  logic [7:0] tx_cnt_r, rx_cnt_r, rx_data_r;
  logic [31:0] prdata_r;
  logic store_q_r, fetch_q_r, rx_full_r;
  hbd_chan_st_t tx_st_r, tx_st_nxt, rx_st_r, rx_st_nxt;
  logic [HBD_PIN_W-1:0] pin_s;
  logic [$clog2(FIFO_DEPTH):0] fifo_lvl;

  hbd_strm_if #(.W(HBD_BYTE_W)) tx_in ();
  hbd_strm_if #(.W(HBD_BYTE_W)) tx_out ();

  // Data bus is synced beside its strobes, so a byte and its strobe edge line up
  // Costs two clocks of latency per strobe edge, hence the three-clock minimum phase
  hbd_sync #(.W(HBD_PIN_W), .RST_VAL(HBD_PIN_RST_VAL)) u_sync (
    .clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .d_i({store_n_i, fetch_n_i, tx_xfer_grant_n_i, rx_xfer_grant_n_i, bus_data_i}),
    .q_o(pin_s)
  );

  wire logic store_s = pin_s[11];
  wire logic fetch_s = pin_s[10];
  wire logic gtx_s = pin_s[9];
  wire logic grx_s = pin_s[8];
  wire logic [7:0] din_s = pin_s[7:0];

  // APB decode
  wire logic acc = psel_i & penable_i;
  wire logic hit_tx = (paddr_i == HBD_TX_CFG_OFS);
  wire logic hit_rx = (paddr_i == HBD_RX_CFG_OFS);
  wire logic hit_len = (paddr_i == HBD_TX_LEN_OFS);
  wire logic hit_st = (paddr_i == HBD_STAT_OFS);
  wire logic hit = hit_tx | hit_rx | hit_len | hit_st;
  wire logic wr_tx = acc & pwrite_i & hit_tx;
  wire logic wr_rx = acc & pwrite_i & hit_rx;
  wire logic wr_len = acc & pwrite_i & hit_len;
  wire logic tx_rst_pls = wr_tx & pwdata_i[HBD_RST_BIT] & ~tx_cfg_r[HBD_RST_BIT];
  wire logic rx_rst_pls = wr_rx & pwdata_i[HBD_RST_BIT] & ~rx_cfg_r[HBD_RST_BIT];
  wire logic [31:0] stat_word = {8'h00, rx_cnt_r, tx_cnt_r, 4'(fifo_lvl), rx_st_r, tx_st_r};
  wire logic [31:0] rd_word = hit_tx ? {24'h0, tx_cfg_r} :
                              hit_rx ? {24'h0, rx_cfg_r} :
                              hit_len ? {24'h0, tx_len_r} :
                              hit_st ? stat_word : 32'h0;

  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~hit;
  assign prdata_o = prdata_r;

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_cfg_r <= HBD_CFG_RST_VAL;
      rx_cfg_r <= HBD_CFG_RST_VAL;
      tx_len_r <= HBD_LEN_RST_VAL;
      prdata_r <= 32'h0;
    end else begin
      if (wr_tx) tx_cfg_r <= pwdata_i[7:0] & HBD_CFG_WMASK;
      if (wr_rx) rx_cfg_r <= pwdata_i[7:0] & HBD_CFG_WMASK;
      if (wr_len) tx_len_r <= pwdata_i[7:0];
      if (psel_i & ~penable_i) prdata_r <= rd_word;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      store_q_r <= 1'b1;
      fetch_q_r <= 1'b1;
    end else begin
      store_q_r <= store_s;
      fetch_q_r <= fetch_s;
    end
  end

  // Memory-to-buffer channel
  wire logic tx_go = tx_cfg_r[HBD_EN_BIT] & hbd_sel_ok(tx_cfg_r[2:0], 1'b0, LINE_ID);
  wire logic tx_str = tx_cfg_r[HBD_TYPE_BIT] ? store_s : fetch_s;
  wire logic tx_str_q = tx_cfg_r[HBD_TYPE_BIT] ? store_q_r : fetch_q_r;
  wire logic tx_act = (tx_st_r == HBD_ACT);
  wire logic tx_last = (tx_cnt_r == tx_len_r);
  // A full FIFO raises the request, so the controller stalls instead of losing bytes
  wire logic tx_take = tx_act & ~gtx_s & tx_str_q & ~tx_str & ~tx_last & tx_in.ready;
  assign tx_xfer_request_n_o = ~(tx_act & ~tx_last & tx_in.ready);
  assign tx_in.data = din_s;
  assign tx_in.valid = tx_take;
  assign tx_out.ready = tx_buf_ready_i;
  assign tx_buf_data_o = tx_out.data;
  assign tx_buf_valid_o = tx_out.valid;

  always_comb begin
    tx_st_nxt = tx_st_r;
    unique case (tx_st_r)
      HBD_IDLE: if (tx_go & tx_buf_room_i) tx_st_nxt = HBD_ACT;
      HBD_ACT: begin
        if (!tx_go) tx_st_nxt = HBD_IDLE;
        else if (tx_last) tx_st_nxt = HBD_DONE;
      end
      HBD_DONE: if (!tx_go | !tx_out.valid) tx_st_nxt = HBD_IDLE;
      default: tx_st_nxt = HBD_IDLE;
    endcase
    if (tx_rst_pls) tx_st_nxt = HBD_IDLE;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_st_r <= HBD_IDLE;
      tx_cnt_r <= 8'h00;
    end else begin
      tx_st_r <= tx_st_nxt;
      if (tx_rst_pls | (tx_st_r == HBD_IDLE)) tx_cnt_r <= 8'h00;
      else if (tx_take) tx_cnt_r <= 8'(tx_cnt_r + 8'h01);
    end
  end

  hbd_fifo #(.W(HBD_BYTE_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .clr_i(tx_rst_pls),
    .in_s(tx_in),
    .out_s(tx_out),
    .level_o(fifo_lvl)
  );

  // Buffer-to-memory channel
  wire logic rx_go = rx_cfg_r[HBD_EN_BIT] & hbd_sel_ok(rx_cfg_r[2:0], 1'b1, LINE_ID);
  wire logic rx_str = rx_cfg_r[HBD_TYPE_BIT] ? store_s : fetch_s;
  wire logic rx_str_q = rx_cfg_r[HBD_TYPE_BIT] ? store_q_r : fetch_q_r;
  wire logic rx_act = (rx_st_r == HBD_ACT);
  wire logic rx_last = (rx_cnt_r == rx_len_r);
  wire logic rx_give = rx_act & ~grx_s & ~rx_str_q & rx_str & rx_full_r;
  wire logic rx_load = rx_buf_valid_i & rx_buf_ready_o;
  assign rx_buf_ready_o = rx_act & ~rx_full_r & ~rx_last;
  assign rx_xfer_request_n_o = ~(rx_act & ~rx_last);
  // Byte is driven while the strobe is low and moves on at its rising edge
  assign bus_data_oe_o = rx_act & ~grx_s & ~rx_str & rx_full_r;
  assign bus_data_o = rx_data_r;

  always_comb begin
    rx_st_nxt = rx_st_r;
    unique case (rx_st_r)
      HBD_IDLE: if (rx_go & rx_buf_msg_i) rx_st_nxt = HBD_ACT;
      HBD_ACT: begin
        if (!rx_go) rx_st_nxt = HBD_IDLE;
        else if (rx_last) rx_st_nxt = HBD_DONE;
      end
      HBD_DONE: if (!rx_go | !rx_buf_msg_i) rx_st_nxt = HBD_IDLE;
      default: rx_st_nxt = HBD_IDLE;
    endcase
    if (rx_rst_pls) rx_st_nxt = HBD_IDLE;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_st_r <= HBD_IDLE;
      rx_cnt_r <= 8'h00;
      rx_len_r <= 8'h00;
      rx_full_r <= 1'b0;
      rx_data_r <= 8'h00;
    end else begin
      rx_st_r <= rx_st_nxt;
      if (rx_st_r == HBD_IDLE) rx_len_r <= rx_buf_len_i;
      if (rx_rst_pls | (rx_st_r == HBD_IDLE)) rx_cnt_r <= 8'h00;
      else if (rx_give) rx_cnt_r <= 8'(rx_cnt_r + 8'h01);
      if (rx_rst_pls | (rx_st_r == HBD_IDLE) | rx_give) rx_full_r <= 1'b0;
      else if (rx_load) rx_full_r <= 1'b1;
      if (rx_load) rx_data_r <= rx_buf_data_i;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_tx_final_take;
    tx_take ##0 (tx_cnt_r == 8'(tx_len_r - 8'h01));
  endsequence
  sequence s_rx_final_give;
    rx_give ##0 (rx_cnt_r == 8'(rx_len_r - 8'h01));
  endsequence

  property p_tx_rst;
    tx_rst_pls |=> (tx_st_r == HBD_IDLE) && (tx_cnt_r == 8'h00) && tx_xfer_request_n_o;
  endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("tx channel not reset");
  property p_rx_rst;
    rx_rst_pls |=> (rx_st_r == HBD_IDLE) && !rx_full_r && rx_xfer_request_n_o;
  endproperty
  a_rx_rst: assert property (p_rx_rst) else $error("rx channel not reset");
  property p_tx_en;
    !tx_cfg_r[HBD_EN_BIT] |=> tx_xfer_request_n_o;
  endproperty
  a_tx_en: assert property (p_tx_en) else $error("tx request while disabled");
  property p_tx_room;
    $rose(tx_act) |-> $past(tx_buf_room_i) && $past(tx_go);
  endproperty
  a_tx_room: assert property (p_tx_room) else $error("tx started without room");
  property p_tx_take;
    tx_take |-> !tx_xfer_request_n_o && !gtx_s ##1 (fifo_lvl != '0);
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("tx byte taken outside grant");
  property p_tx_store;
    tx_act && !gtx_s && tx_cfg_r[HBD_TYPE_BIT] && $fell(store_s) && !tx_last && tx_in.ready |-> tx_take;
  endproperty
  a_tx_store: assert property (p_tx_store) else $error("store strobe byte missed");
  property p_tx_sel;
    !hbd_sel_ok(tx_cfg_r[2:0], 1'b0, LINE_ID) |=> (tx_st_r != HBD_ACT);
  endproperty
  a_tx_sel: assert property (p_tx_sel) else $error("tx active on bad line code");
  property p_rx_msg;
    $rose(rx_act) |-> $past(rx_buf_msg_i) && $past(rx_go);
  endproperty
  a_rx_msg: assert property (p_rx_msg) else $error("rx started without message");
  property p_rx_give;
    rx_give |-> !rx_xfer_request_n_o && !grx_s;
  endproperty
  a_rx_give: assert property (p_rx_give) else $error("rx byte given outside grant");
  property p_rx_drive;
    bus_data_oe_o |-> rx_full_r && (rx_cfg_r[HBD_TYPE_BIT] ? !store_s : !fetch_s);
  endproperty
  a_rx_drive: assert property (p_rx_drive) else $error("bus driven off strobe");
  property p_rx_sel;
    !hbd_sel_ok(rx_cfg_r[2:0], 1'b1, LINE_ID) |=> (rx_st_r != HBD_ACT);
  endproperty
  a_rx_sel: assert property (p_rx_sel) else $error("rx active on bad line code");
  property p_done;
    s_tx_final_take |=> tx_xfer_request_n_o [*2];
  endproperty
  a_done: assert property (p_done) else $error("tx request held after message");
  property p_rx_done;
    s_rx_final_give |=> rx_xfer_request_n_o [*2];
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("rx request held after message");
  property p_rx_en;
    !rx_cfg_r[HBD_EN_BIT] |=> rx_xfer_request_n_o;
  endproperty
  a_rx_en: assert property (p_rx_en) else $error("rx request while disabled");
  // Length is latched only while idle, so the count can never pass it
  property p_rx_cnt;
    rx_act |-> (rx_cnt_r <= rx_len_r);
  endproperty
  a_rx_cnt: assert property (p_rx_cnt) else $error("rx count past message length");
  // The byte must stand on the bus for the whole low strobe
  property p_rx_hold;
    bus_data_oe_o && $past(bus_data_oe_o) |-> $stable(bus_data_o);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("bus byte changed while driven");
  property p_rx_load;
    rx_load && !rx_rst_pls |=> rx_full_r && (bus_data_o == $past(rx_buf_data_i));
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("rx byte not held after load");
endmodule
`default_nettype wire

// [hbd_dma_model.sv]
// Purpose: Model of the external transfer controller and its memory
// Assumes: Strobe low phase 5 clocks, high phase 5 clocks on rx and 6 clocks between tx bytes
// Notes: A released data bus shows the inverse of the last byte
`default_nettype none
module hbd_dma_model (
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic tx_store_i,
  input wire logic rx_store_i,
  input wire logic tx_req_n_i,
  input wire logic rx_req_n_i,
  input wire logic [7:0] bus_i,
  output logic tx_grant_n_o,
  output logic rx_grant_n_o,
  output logic store_n_o,
  output logic fetch_n_o,
  output logic [7:0] bus_o,
  output logic got_o,
  output logic [7:0] got_byte_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx_q[$];

  task automatic strobe(input logic use_store, input logic is_rx);
    if (use_store)
      store_n_o <= 1'b0;
    else
      fetch_n_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    if (is_rx) begin
      got_o <= 1'b1;
      got_byte_o <= bus_i;
    end
    if (use_store)
      store_n_o <= 1'b1;
    else
      fetch_n_o <= 1'b1;
    @(posedge clk_i);
    got_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  initial begin
    tx_grant_n_o = 1'b1;
    rx_grant_n_o = 1'b1;
    store_n_o = 1'b1;
    fetch_n_o = 1'b1;
    bus_o = 8'h5a;
    got_o = 1'b0;
    got_byte_o = 8'h00;
    forever begin
      @(posedge clk_i);
      if (!hold_i && !tx_req_n_i && tx_q.size() > 0) begin
        repeat ($urandom_range(3)) @(posedge clk_i);
        tx_grant_n_o <= 1'b0;
        // Store held low marks a write when the fetch line strobes
        store_n_o <= tx_store_i;
        while (!tx_req_n_i && tx_q.size() > 0) begin
          bus_o <= tx_q.pop_front();
          @(posedge clk_i);
          strobe(tx_store_i, 1'b0);
        end
        tx_grant_n_o <= 1'b1;
        store_n_o <= 1'b1;
        bus_o <= ~bus_o;
      end else if (!hold_i && !rx_req_n_i) begin
        repeat ($urandom_range(3)) @(posedge clk_i);
        rx_grant_n_o <= 1'b0;
        fetch_n_o <= ~rx_store_i;
        @(posedge clk_i);
        while (!rx_req_n_i) strobe(rx_store_i, 1'b1);
        rx_grant_n_o <= 1'b1;
        fetch_n_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
// Purpose: Self-checking bench for the buffer transfer block
// Assumes: Zero wait APB, partner model on the pin side
// Notes: Expected results queue up and are popped as outputs appear
`default_nettype none
module tb
  import hbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, pready, pslverr, store_n, fetch_n, txg_n, rxg_n, txr_n, rxr_n, bus_oe, txb_valid, rxb_ready, got;
  logic rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, room = 1'b1, rx_msg = 1'b0, rxb_valid = 1'b0;
  logic hold = 1'b0, tx_st = 1'b0, rx_st = 1'b0, stall = 1'b0, txb_ready = 1'b0;
  logic [7:0] paddr = 8'h00, rx_len = 8'h00, rxb_data = 8'h00;
  logic [7:0] bus_dev, p_bus, bus_w, txb_data, got_byte;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [32:0] reg_q[$];
  logic [7:0] txe_q[$], rxe_q[$];
  int failures = 0;
  int num_checks = 0;
  assign bus_w = bus_oe ? bus_dev : p_bus;

  hbd_xfer_top hbd_xfer_top_inst (
    .core_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .store_n_i(store_n), .fetch_n_i(fetch_n), .tx_xfer_grant_n_i(txg_n), .rx_xfer_grant_n_i(rxg_n),
    .tx_xfer_request_n_o(txr_n), .rx_xfer_request_n_o(rxr_n), .bus_data_i(bus_w), .bus_data_o(bus_dev),
    .bus_data_oe_o(bus_oe), .tx_buf_room_i(room), .tx_buf_data_o(txb_data), .tx_buf_valid_o(txb_valid),
    .tx_buf_ready_i(txb_ready), .rx_buf_msg_i(rx_msg), .rx_buf_len_i(rx_len), .rx_buf_data_i(rxb_data),
    .rx_buf_valid_i(rxb_valid), .rx_buf_ready_o(rxb_ready));
  hbd_dma_model hbd_dma_model_inst (
    .clk_i(clk), .hold_i(hold), .tx_store_i(tx_st), .rx_store_i(rx_st), .tx_req_n_i(txr_n),
    .rx_req_n_i(rxr_n), .bus_i(bus_w), .tx_grant_n_o(txg_n), .rx_grant_n_o(rxg_n), .store_n_o(store_n),
    .fetch_n_o(fetch_n), .bus_o(p_bus), .got_o(got), .got_byte_o(got_byte));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic note(input logic bad, input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (bad) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_reg(input logic [32:0] e, input logic [32:0] g);
    note(g !== e, e, g);
  endtask
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    note(g !== e, {25'h0, e}, {25'h0, g});
  endtask
  // Requests settle after the edge, so look half a cycle later
  task automatic cmp_req(input logic [1:0] e);
    @(negedge clk);
    note({txr_n, rxr_n} !== e, {31'h0, e}, {31'h0, txr_n, rxr_n});
    @(posedge clk);
  endtask
  task automatic hang;
    note(1'b1, 33'h0, 33'h1);
    wrap_up();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    reg_q.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  task automatic wait_for(input logic on_model, input int k);
    int n;
    n = 0;
    while ((on_model ? hbd_dma_model_inst.tx_q.size() > k : txe_q.size() + rxe_q.size() > 0) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) hang();
  endtask
  task automatic tx_run(input logic mode, input logic [7:0] n, input logic [7:0] give);
    logic [7:0] v;
    tx_st <= mode;
    room <= 1'b1;
    apb(1'b1, HBD_TX_LEN_OFS, n);
    for (int i = 0; i < give; i++) begin
      v = 8'($urandom);
      hbd_dma_model_inst.tx_q.push_back(v);
      txe_q.push_back(v);
    end
    apb(1'b1, HBD_TX_CFG_OFS, {2'b01, mode, 5'h0});
    // The channel has started by now; the buffer's room is spoken for, so no re-arm after the message
    room <= 1'b0;
  endtask
  task automatic tx_end;
    wait_for(1'b0, 0);
    tick(10);
    cmp_req(2'b11);
    apb(1'b1, HBD_TX_CFG_OFS, 8'h00);
  endtask
  task automatic feed(input logic [7:0] n);
    logic [7:0] v;
    int t;
    for (int i = 0; i < n; i++) begin
      v = 8'($urandom);
      rxb_data <= v;
      rxb_valid <= 1'b1;
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (rxb_ready !== 1'b1 && t < 500);
      if (t >= 500) hang();
      rxe_q.push_back(v);
    end
    rxb_valid <= 1'b0;
  endtask
  task automatic rx_run(input logic mode, input logic [7:0] n);
    rx_st <= mode;
    rx_len <= n;
    rx_msg <= 1'b1;
    fork
      feed(n);
      apb(1'b1, HBD_RX_CFG_OFS, {2'b01, mode, 5'h0});
    join
    wait_for(1'b0, 0);
    tick(10);
    cmp_req(2'b11);
    rx_msg <= 1'b0;
    apb(1'b1, HBD_RX_CFG_OFS, 8'h00);
    done("rx run");
  endtask

  // Buffer side takes bytes at random unless stalled
  always @(posedge clk) txb_ready <= !stall && ($urandom_range(3) != 0);

  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) cmp_reg(reg_q.pop_front(), {pslverr, prdata});
    if (txb_valid && txb_ready) cmp_byte(txe_q.pop_front(), txb_data);
    if (got) cmp_byte(rxe_q.pop_front(), got_byte);
  end

  initial begin
    void'($urandom(32'he4d5bed4));
    tick(2);
    rstn <= 1'b1;
    tick(1);
    rd(HBD_TX_CFG_OFS, {25'h0, HBD_CFG_RST_VAL});
    rd(HBD_RX_CFG_OFS, {25'h0, HBD_CFG_RST_VAL});
    rd(HBD_TX_LEN_OFS, {25'h0, HBD_LEN_RST_VAL});
    rd(HBD_STAT_OFS, 33'h0);
    rd(8'h10, {1'b1, 32'h0});
    apb(1'b1, HBD_TX_CFG_OFS, 8'hff);
    rd(HBD_TX_CFG_OFS, {25'h0, HBD_CFG_WMASK});
    apb(1'b1, HBD_TX_CFG_OFS, 8'h00);
    done("registers");
    rx_msg <= 1'b1;
    rx_len <= 8'h02;
    for (int s = 1; s < 8; s++) begin
      apb(1'b1, HBD_TX_CFG_OFS, 8'h40 | 8'(s));
      apb(1'b1, HBD_RX_CFG_OFS, 8'h40 | 8'(s));
      tick(6);
      cmp_req(2'b11);
    end
    apb(1'b1, HBD_RX_CFG_OFS, 8'h00);
    apb(1'b1, HBD_TX_CFG_OFS, 8'h00);
    rx_msg <= 1'b0;
    room <= 1'b0;
    apb(1'b1, HBD_TX_CFG_OFS, 8'h60);
    tick(6);
    cmp_req(2'b11);
    room <= 1'b1;
    tick(6);
    cmp_req(2'b01);
    apb(1'b1, HBD_TX_CFG_OFS, 8'h00);
    cmp_req(2'b11);
    done("line codes and room");
    tx_run(1'b1, 8'd5, 8'd5);
    tx_end();
    tx_run(1'b0, 8'd4, 8'd4);
    tx_end();
    done("tx both strobe roles");
    stall <= 1'b1;
    tx_run(1'b1, 8'd12, 8'd12);
    wait_for(1'b1, 4);
    tick(12);
    cmp_req(2'b11);
    rd(HBD_STAT_OFS, 33'h881);
    stall <= 1'b0;
    tx_end();
    done("fifo full");
    stall <= 1'b1;
    tx_run(1'b1, 8'd6, 8'd3);
    wait_for(1'b1, 0);
    tick(12);
    cmp_req(2'b01);
    // Enable stays set, so only the reset edge can idle the channel
    apb(1'b1, HBD_TX_CFG_OFS, 8'hc0);
    rd(HBD_STAT_OFS, 33'h0);
    cmp_req(2'b11);
    txe_q.delete();
    apb(1'b1, HBD_TX_CFG_OFS, 8'h00);
    stall <= 1'b0;
    done("tx reset");
    rx_run(1'b0, 8'd3);
    rx_run(1'b1, 8'd5);
    hold <= 1'b1;
    rx_len <= 8'd4;
    rx_msg <= 1'b1;
    apb(1'b1, HBD_RX_CFG_OFS, 8'h40);
    tick(4);
    cmp_req(2'b10);
    rx_msg <= 1'b0;
    tick(4);
    cmp_req(2'b10);
    // Enable stays set and no message waits, so only the reset edge can idle the channel
    apb(1'b1, HBD_RX_CFG_OFS, 8'hc0);
    rd(HBD_STAT_OFS, 33'h0);
    cmp_req(2'b11);
    hold <= 1'b0;
    apb(1'b1, HBD_RX_CFG_OFS, 8'h00);
    done("rx reset");
    wrap_up();
  end
endmodule
`default_nettype wire
